// ==== hdl/adcseq_defs.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the conversion sequencer.
 Assumes APB with 8-bit byte addresses and 32-bit data.
*/
`ifndef ADCSEQ_DEFS_SVH
`define ADCSEQ_DEFS_SVH

`define ADCSEQ_OFF_CTRL 8'h00
`define ADCSEQ_OFF_CLKDIV 8'h04
`define ADCSEQ_OFF_TRIG 8'h08
`define ADCSEQ_OFF_CHAN 8'h0C
`define ADCSEQ_OFF_STATUS 8'h10
`define ADCSEQ_OFF_RESULT 8'h14
`define ADCSEQ_OFF_PREV 8'h18
`define ADCSEQ_OFF_ACC 8'h1C
`define ADCSEQ_OFF_ERR 8'h20
`define ADCSEQ_OFF_SETPT 8'h24
`define ADCSEQ_OFF_THRESH 8'h28

`define ADCSEQ_CTRL_ON 0
`define ADCSEQ_CTRL_GO 1
`define ADCSEQ_CTRL_RC 2
`define ADCSEQ_CTRL_RJUST 3
`define ADCSEQ_CTRL_REPEAT 4
`define ADCSEQ_CTRL_KEEP 5
`define ADCSEQ_CTRL_DOUBLE_SAMPLE_ENABLE 6
`define ADCSEQ_CTRL_IE 7

`define ADCSEQ_ST_DONE 0
`define ADCSEQ_ST_COMPUTATION_FLAG 1
`define ADCSEQ_ST_THR 2
`define ADCSEQ_ST_PDOWN 3

`define ADCSEQ_TRG_OFF 5'h00
`define ADCSEQ_TRG_CHWR 5'h1F
`define ADCSEQ_TRG_RESRD 5'h1D
`define ADCSEQ_TRG_ERRRD 5'h1C

`define ADCSEQ_RST_CLKDIV 7'h00
`define ADCSEQ_RST_THRESH 13'h0000

`define ADCSEQ_CLK_MHZ 125
`define ADCSEQ_INSTR_NS 32
`define ADCSEQ_INSTR_CYC ((`ADCSEQ_INSTR_NS * `ADCSEQ_CLK_MHZ + 999) / 1000)
`define ADCSEQ_RC_TAD_NS 2000
`define ADCSEQ_RC_TAD_CYC ((`ADCSEQ_RC_TAD_NS * `ADCSEQ_CLK_MHZ) / 1000)

`endif

// ==== hdl/adcseq_pkg.sv ====
/*
 Types of the conversion sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adcseq_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_CONV = 4'h4,
      ST_CALC = 4'h8
   } adcseq_state_e;
endpackage : adcseq_pkg

// ==== hdl/adcseq_clkdiv.sv ====
/*
 Enable-pulse divider: one-cycle tick every period_m1+1 clocks while run is high.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
module adcseq_clkdiv #(
   parameter int W = 8
) (
   input wire logic clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic run, // Divider runs while high
   input wire logic [W-1:0] period_m1, // Period minus one
   output logic tick // One-cycle enable pulse
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic tick_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (!run) begin
         cnt_nxt = '0;
      end else if (cnt_r >= period_m1) begin
         cnt_nxt = '0;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = W'(cnt_r + 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick <= tick_nxt;
      end
   end
endmodule : adcseq_clkdiv

// ==== hdl/adcseq_top.sv ====
/*
 Successive-approximation conversion sequencer with APB registers: clock choice, start sources,
 completion actions, abort, sleep handling and result formatting.
 Assumes an external comparator answering dac_trial on cmp_in, and synchronous trigger inputs.
*/
// Contract
// - System clock path divides by 2*n, n from 1 to 128 by divider select.
// - Source select 1 runs conversion timing from the RC period, a pclk divide by RC_TAD_CYC.
// - Done flag sets at every conversion end regardless of interrupt enable.
// - In sleep only the RC clock starts conversions; other sources do not, but one already running finishes.
// - Completion in sleep with interrupt enabled raises a wake-up request.
// - Result reads left or right justified per the justify select bit.
// - Software result writes are stored right justified regardless of format.
// - With module on, start by go write, external trigger or repeat retrigger.
// - At completion old result goes to previous register if keep bit set.
// - Completion clears go unless repeat, sets done and computation_flag flags, updates accumulator.
// - Error and threshold evaluated every conversion, or every second with double sampling.
// - Error and threshold are computed after the conversion finishes.
// - Clearing go mid-conversion loads partial result filled with last bit.
// - Reset restores all registers, turns module off, abandons conversion.
// - RC clock delays conversion start by one instruction cycle.
// - Sleep completion without interrupt enable powers down, on bit stays set.
// - Trigger in sleep with RC clock converts and sets done flag.
// - Trigger in sleep without RC clock is latched until sleep ends.
// - Rising edge of selected trigger source sets go in hardware.
// - Five-bit trigger select: 00000 disables, 11111 uses channel register write.
`timescale 1ns/1ps
`include "adcseq_defs.svh"
module adcseq_top #(
   parameter int RC_TAD_CYC = `ADCSEQ_RC_TAD_CYC,
   parameter int INSTR_CYC = `ADCSEQ_INSTR_CYC
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [31:0] trig_in, // Trigger sources by select code
   input wire logic sleep_mode, // Device is in sleep
   input wire logic cmp_in, // Comparator: input at or above trial
   output logic [11:0] dac_trial, // Trial code under test
   output logic done_flag, // Conversion done flag
   output logic threshold_flag, // Threshold flag
   output logic wake_req // Wake-up request
);
   ////////////////////////////////////////////////////////////////////////////////
   logic setup, acc_ph, wr, rd, hit;
   logic [31:0] rd_mux;
   logic [31:0] prdata_nxt;
   logic on_r, go_r, cs_r, rjust_r, rep_r, keep_r, double_sample_enable_r, ie_r;
   logic on_nxt, go_nxt, cs_nxt, rjust_nxt, rep_nxt, keep_nxt, double_sample_enable_nxt, ie_nxt;
   logic [6:0] clkdiv_r, clkdiv_nxt;
   logic [4:0] trgsel_r, trgsel_nxt;
   logic [5:0] chan_r, chan_nxt;
   logic done_nxt, computation_flag_r, computation_flag_nxt, thr_nxt, pdown_r, pdown_nxt, wake_nxt;
   logic pend_r, pend_nxt, pair_r, pair_nxt, calc_r, calc_nxt, last_r, last_nxt, trig_q_r;
   logic [11:0] result_r, result_nxt, prev_r, prev_nxt, sar_r, sar_nxt, setpt_r, setpt_nxt, dac_nxt, fin;
   logic [17:0] acc_r, acc_nxt;
   logic [12:0] err_r, err_nxt, thresh_r, thresh_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [2:0] dly_r, dly_nxt;
   adcseq_pkg::adcseq_state_e state_r, state_nxt;
   logic sys_tick, rc_tick, tick, trig_edge, sw_trig, allowed, cmpl, cmpl_sleep;

   assign setup = psel & ~penable;
   assign acc_ph = psel & penable & pready;
   assign wr = acc_ph & pwrite;
   assign rd = acc_ph & ~pwrite;

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion timing enables; both run on pclk so no crossing can drop a start
   adcseq_clkdiv #(.W(8)) u_sysdiv (
      .clk(pclk),
      .rstn(presetn),
      .run(on_r & ~cs_r & (state_r == adcseq_pkg::ST_CONV)), // Restarts per conversion: full first period
      .period_m1({clkdiv_r, 1'b1}), // 2*n-1 for n = field+1
      .tick(sys_tick)
   );
   adcseq_clkdiv #(.W(8)) u_rcdiv (
      .clk(pclk),
      .rstn(presetn),
      .run(on_r & cs_r & (state_r == adcseq_pkg::ST_CONV)),
      .period_m1(8'(RC_TAD_CYC - 1)),
      .tick(rc_tick)
   );
   assign tick = cs_r ? rc_tick : sys_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Register read mux, registered in the setup phase so every access has zero waits
   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `ADCSEQ_OFF_CTRL: rd_mux[7:0] = {ie_r, double_sample_enable_r, keep_r, rep_r, rjust_r, cs_r, go_r, on_r};
         `ADCSEQ_OFF_CLKDIV: rd_mux[6:0] = clkdiv_r;
         `ADCSEQ_OFF_TRIG: rd_mux[4:0] = trgsel_r;
         `ADCSEQ_OFF_CHAN: rd_mux[5:0] = chan_r;
         `ADCSEQ_OFF_STATUS: rd_mux[3:0] = {pdown_r, threshold_flag, computation_flag_r, done_flag};
         `ADCSEQ_OFF_RESULT: rd_mux[15:0] = rjust_r ? {4'h0, result_r} : {result_r, 4'h0};
         `ADCSEQ_OFF_PREV: rd_mux[11:0] = prev_r;
         `ADCSEQ_OFF_ACC: rd_mux[17:0] = acc_r;
         `ADCSEQ_OFF_ERR: rd_mux[12:0] = err_r;
         `ADCSEQ_OFF_SETPT: rd_mux[11:0] = setpt_r;
         `ADCSEQ_OFF_THRESH: rd_mux[12:0] = thresh_r;
         default: hit = 1'b0;
      endcase
      prdata_nxt = setup ? rd_mux : prdata;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= prdata_nxt;
         pready <= setup;
         pslverr <= setup & ~hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Start sources
   always_comb begin
      trig_edge = 1'b0;
      sw_trig = 1'b0;
      case (trgsel_r)
         `ADCSEQ_TRG_OFF: trig_edge = 1'b0;
         `ADCSEQ_TRG_CHWR: sw_trig = wr & (paddr == `ADCSEQ_OFF_CHAN);
         `ADCSEQ_TRG_RESRD: sw_trig = rd & (paddr == `ADCSEQ_OFF_RESULT);
         `ADCSEQ_TRG_ERRRD: sw_trig = rd & (paddr == `ADCSEQ_OFF_ERR);
         default: trig_edge = trig_in[trgsel_r] & ~trig_q_r;
      endcase
   end
   assign allowed = ~sleep_mode | cs_r;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      {on_nxt, go_nxt, cs_nxt, rjust_nxt} = {on_r, go_r, cs_r, rjust_r};
      {rep_nxt, keep_nxt, double_sample_enable_nxt, ie_nxt} = {rep_r, keep_r, double_sample_enable_r, ie_r};
      clkdiv_nxt = clkdiv_r;
      trgsel_nxt = trgsel_r;
      chan_nxt = chan_r;
      done_nxt = done_flag;
      computation_flag_nxt = computation_flag_r;
      thr_nxt = threshold_flag;
      pdown_nxt = pdown_r;
      wake_nxt = wake_req & sleep_mode;
      pend_nxt = pend_r;
      pair_nxt = pair_r;
      calc_nxt = calc_r;
      last_nxt = last_r;
      result_nxt = result_r;
      prev_nxt = prev_r;
      sar_nxt = sar_r;
      setpt_nxt = setpt_r;
      acc_nxt = acc_r;
      err_nxt = err_r;
      thresh_nxt = thresh_r;
      bit_nxt = bit_r;
      dly_nxt = dly_r;
      state_nxt = state_r;
      cmpl = 1'b0;
      fin = sar_r;
      if (wr) begin
         case (paddr)
            `ADCSEQ_OFF_CTRL: begin
               on_nxt = pwdata[`ADCSEQ_CTRL_ON];
               go_nxt = pwdata[`ADCSEQ_CTRL_GO] & on_r; // A go in the turn-on write is dropped
               cs_nxt = pwdata[`ADCSEQ_CTRL_RC];
               rjust_nxt = pwdata[`ADCSEQ_CTRL_RJUST];
               rep_nxt = pwdata[`ADCSEQ_CTRL_REPEAT];
               keep_nxt = pwdata[`ADCSEQ_CTRL_KEEP];
               double_sample_enable_nxt = pwdata[`ADCSEQ_CTRL_DOUBLE_SAMPLE_ENABLE];
               ie_nxt = pwdata[`ADCSEQ_CTRL_IE];
               pdown_nxt = 1'b0;
            end
            `ADCSEQ_OFF_CLKDIV: clkdiv_nxt = pwdata[6:0];
            `ADCSEQ_OFF_TRIG: trgsel_nxt = pwdata[4:0];
            `ADCSEQ_OFF_CHAN: chan_nxt = pwdata[5:0];
            `ADCSEQ_OFF_STATUS: begin
               done_nxt = done_flag & ~pwdata[`ADCSEQ_ST_DONE];
               computation_flag_nxt = computation_flag_r & ~pwdata[`ADCSEQ_ST_COMPUTATION_FLAG];
               thr_nxt = threshold_flag & ~pwdata[`ADCSEQ_ST_THR];
            end
            `ADCSEQ_OFF_RESULT: result_nxt = pwdata[11:0];
            `ADCSEQ_OFF_SETPT: setpt_nxt = pwdata[11:0];
            `ADCSEQ_OFF_THRESH: thresh_nxt = pwdata[12:0];
            default: ;
         endcase
      end
      if (on_r & (trig_edge | sw_trig)) begin
         pend_nxt = 1'b1; // Held through sleep until converting is allowed
      end
      case (state_r)
         adcseq_pkg::ST_IDLE: begin
            if (on_r & ~pdown_r & allowed & (go_nxt | pend_r)) begin // Go clear in same cycle wins unless a trigger is pending
               go_nxt = 1'b1;
               pend_nxt = 1'b0;
               bit_nxt = 4'hB;
               sar_nxt = 12'h000;
               last_nxt = 1'b0;
               dly_nxt = 3'(INSTR_CYC - 1);
               state_nxt = cs_r ? adcseq_pkg::ST_WAIT : adcseq_pkg::ST_CONV;
            end
         end
         adcseq_pkg::ST_WAIT: begin
            if (!go_nxt) begin
               state_nxt = adcseq_pkg::ST_IDLE;
            end else if (dly_r == 3'h0) begin
               state_nxt = adcseq_pkg::ST_CONV;
            end else begin
               dly_nxt = 3'(dly_r - 1'b1);
            end
         end
         adcseq_pkg::ST_CONV: begin
            if (!go_nxt) begin
               fin = sar_r | ({12{last_r}} & 12'(12'(12'h002 << bit_r) - 12'h001));
               cmpl = 1'b1;
            end else if (tick) begin
               sar_nxt[bit_r] = cmp_in;
               last_nxt = cmp_in;
               fin = sar_nxt;
               if (bit_r == 4'h0) begin
                  cmpl = 1'b1;
               end else begin
                  bit_nxt = 4'(bit_r - 1'b1);
               end
            end
         end
         adcseq_pkg::ST_CALC: begin
            if (calc_r) begin // Runs one cycle after completion
               err_nxt = double_sample_enable_r ? 13'({1'b0, result_r} - {1'b0, prev_r}) : 13'({1'b0, result_r} - {1'b0, setpt_r});
               if ($signed(err_nxt) > $signed(thresh_r)) begin
                  thr_nxt = 1'b1;
               end
            end
            state_nxt = adcseq_pkg::ST_IDLE;
         end
         default: state_nxt = adcseq_pkg::ST_IDLE;
      endcase
      if (cmpl) begin
         if (keep_r) begin
            prev_nxt = result_r;
         end
         result_nxt = fin;
         done_nxt = 1'b1;
         computation_flag_nxt = 1'b1;
         acc_nxt = 18'(acc_r + {6'h00, fin});
         go_nxt = go_nxt & rep_r; // Kept high for the repeat retrigger
         pair_nxt = double_sample_enable_r & ~pair_r; // Pairing restarts while double sampling is off
         calc_nxt = ~double_sample_enable_r | pair_r;
         state_nxt = adcseq_pkg::ST_CALC;
         if (sleep_mode & ie_r) begin
            wake_nxt = 1'b1;
         end
         if (sleep_mode & ~ie_r) begin
            pdown_nxt = 1'b1; // On bit untouched
         end
      end
      if (!on_r) begin
         go_nxt = 1'b0;
         pend_nxt = 1'b0;
         state_nxt = adcseq_pkg::ST_IDLE;
      end
      dac_nxt = (state_nxt == adcseq_pkg::ST_CONV) ? (sar_nxt | 12'(12'h001 << bit_nxt)) : 12'h000;
   end
   assign cmpl_sleep = cmpl & sleep_mode;

   // Reset returns every register to its reset value and drops any conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {on_r, go_r, cs_r, rjust_r, rep_r, keep_r, double_sample_enable_r, ie_r} <= 8'h00;
         clkdiv_r <= `ADCSEQ_RST_CLKDIV;
         trgsel_r <= `ADCSEQ_TRG_OFF;
         chan_r <= 6'h00;
         {done_flag, computation_flag_r, threshold_flag, pdown_r, wake_req} <= 5'h00;
         {pend_r, pair_r, calc_r, last_r, trig_q_r} <= 5'h00;
         result_r <= 12'h000;
         prev_r <= 12'h000;
         sar_r <= 12'h000;
         setpt_r <= 12'h000;
         acc_r <= 18'h00000;
         err_r <= 13'h0000;
         thresh_r <= `ADCSEQ_RST_THRESH;
         bit_r <= 4'h0;
         dly_r <= 3'h0;
         dac_trial <= 12'h000;
         state_r <= adcseq_pkg::ST_IDLE;
      end else begin
         {on_r, go_r, cs_r, rjust_r} <= {on_nxt, go_nxt, cs_nxt, rjust_nxt};
         {rep_r, keep_r, double_sample_enable_r, ie_r} <= {rep_nxt, keep_nxt, double_sample_enable_nxt, ie_nxt};
         clkdiv_r <= clkdiv_nxt;
         trgsel_r <= trgsel_nxt;
         chan_r <= chan_nxt;
         {done_flag, computation_flag_r, threshold_flag, pdown_r, wake_req} <= {done_nxt, computation_flag_nxt, thr_nxt, pdown_nxt, wake_nxt};
         {pend_r, pair_r, calc_r, last_r, trig_q_r} <= {pend_nxt, pair_nxt, calc_nxt, last_nxt, trig_in[trgsel_r]};
         result_r <= result_nxt;
         prev_r <= prev_nxt;
         sar_r <= sar_nxt;
         setpt_r <= setpt_nxt;
         acc_r <= acc_nxt;
         err_r <= err_nxt;
         thresh_r <= thresh_nxt;
         bit_r <= bit_nxt;
         dly_r <= dly_nxt;
         dac_trial <= dac_nxt;
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_done_on_cmpl: assert property (cmpl |=> done_flag && state_r == adcseq_pkg::ST_CALC)
      else $error("done flag not set at completion");
   a_done_sticky: assert property (done_flag && !(wr && paddr == `ADCSEQ_OFF_STATUS) |=> done_flag)
      else $error("done flag cleared by hardware");
   a_sleep_block: assert property (sleep_mode && !cs_r && state_r == adcseq_pkg::ST_IDLE
      |=> state_r != adcseq_pkg::ST_CONV && state_r != adcseq_pkg::ST_WAIT)
      else $error("conversion started in sleep without RC clock");
   a_wake_raise: assert property (cmpl_sleep && ie_r |=> wake_req)
      else $error("no wake request after sleep completion");
   a_pdown_keep_on: assert property (cmpl_sleep && !ie_r && on_r |=> pdown_r && on_r)
      else $error("sleep completion did not power down");
   a_read_format: assert property (setup && paddr == `ADCSEQ_OFF_RESULT
      |=> prdata == ($past(rjust_r) ? {20'h00000, $past(result_r)} : {16'h0000, $past(result_r), 4'h0}))
      else $error("result read has wrong justification");
   a_go_held: assert property (state_r == adcseq_pkg::ST_CONV ##1 state_r == adcseq_pkg::ST_CONV
      |-> $past(go_r))
      else $error("go low during conversion");
   a_go_cleared: assert property (cmpl && !rep_r |=> !go_r)
      else $error("go not cleared at completion");
   a_prev_copy: assert property (cmpl && keep_r |=> prev_r == $past(result_r))
      else $error("previous result not copied");
   a_rc_delay: assert property (state_r == adcseq_pkg::ST_CONV && $past(state_r) == adcseq_pkg::ST_WAIT
      |-> $past(state_r, 4) == adcseq_pkg::ST_WAIT)
      else $error("RC start delay too short");
   a_off_idle: assert property (!on_r |=> state_r == adcseq_pkg::ST_IDLE && !go_r)
      else $error("conversion runs while module off");

   c_full_conv: cover property (state_r == adcseq_pkg::ST_CONV && tick && bit_r == 4'h0);
   c_abort: cover property (state_r == adcseq_pkg::ST_CONV && !go_nxt);
   c_rc_wait: cover property (state_r == adcseq_pkg::ST_WAIT ##1 state_r == adcseq_pkg::ST_CONV);
   c_threshold: cover property (!threshold_flag ##1 threshold_flag);
endmodule : adcseq_top

// ==== dv/adc_conversion_sequencer_tb.sv ====
/*
 Self-checking bench of the conversion sequencer: APB traffic, conversions, triggers and sleep handling.
 Assumes the design files are compiled first and the include path reaches hdl/.
*/
`timescale 1ns/1ps
`include "adcseq_defs.svh"
module adc_conversion_sequencer_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode, cmp_in;
   logic done_flag, threshold_flag, wake_req;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, trig_in;
   logic [11:0] dac_trial, ana;
   logic [32:0] exp_q[$];
   bit chk_q[$];
   logic [32:0] exp_v;
   bit exp_c;
   int error_cnt = 0;
   int total_checks = 0;

   adcseq_top #(.RC_TAD_CYC(4), .INSTR_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trig_in(trig_in), .sleep_mode(sleep_mode), .cmp_in(cmp_in), .dac_trial(dac_trial),
      .done_flag(done_flag), .threshold_flag(threshold_flag), .wake_req(wake_req));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Comparator seen by the converter: input level held in ana
   always @(posedge pclk) cmp_in <= (ana >= dac_trial);

   // Read results are taken at the completing access edge
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
         exp_v = exp_q.pop_front();
         exp_c = chk_q.pop_front();
         if (exp_c) cmp({pslverr, prdata}, exp_v);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e, input bit c);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) begin
         exp_q.push_back(e);
         chk_q.push_back(c);
      end
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (pready !== 1'b1) cmp({32'h0, pready}, 33'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, 1'b0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e, 1'b1);
   endtask : rd

   task automatic wait_done(output int n);
      n = 0;
      while (done_flag !== 1'b1 && n < 400) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 400) cmp({32'h0, done_flag}, 33'h1);
   endtask : wait_done

   task automatic pulse(input int k);
      trig_in[k] <= 1'b1;
      @(posedge pclk);
      trig_in <= 32'h0;
      @(posedge pclk);
   endtask : pulse

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      end_of_test();
   end

   initial begin
      int n;
      logic [11:0] v;
      int codes[7];
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      trig_in = 32'h0;
      sleep_mode = 1'b0;
      ana = 12'h000;
      void'($urandom(50));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`ADCSEQ_OFF_CTRL, 33'h0);
      rd(`ADCSEQ_OFF_CLKDIV, 33'h0);
      rd(`ADCSEQ_OFF_TRIG, 33'h0);
      rd(`ADCSEQ_OFF_STATUS, 33'h0);
      rd(8'h40, {1'b1, 32'h0});
      wr(`ADCSEQ_OFF_CTRL, 32'h03);
      rd(`ADCSEQ_OFF_CTRL, 33'h01);
      v = 12'($urandom);
      wr(`ADCSEQ_OFF_RESULT, {20'h0, v});
      rd(`ADCSEQ_OFF_RESULT, {17'h0, v, 4'h0});
      wr(`ADCSEQ_OFF_CTRL, 32'h29);
      rd(`ADCSEQ_OFF_RESULT, {21'h0, v});
      // Conversion on system clock divided by 8
      ana = 12'($urandom) | 12'h001;
      wr(`ADCSEQ_OFF_CLKDIV, 32'h3);
      wr(`ADCSEQ_OFF_CTRL, 32'h2B);
      rd(`ADCSEQ_OFF_CTRL, 33'h2B);
      wait_done(n);
      cmp({32'h0, (n >= 80 && n <= 104)}, 33'h1);
      repeat (4) @(posedge pclk);
      rd(`ADCSEQ_OFF_CTRL, 33'h29);
      rd(`ADCSEQ_OFF_RESULT, {21'h0, ana});
      rd(`ADCSEQ_OFF_PREV, {21'h0, v});
      rd(`ADCSEQ_OFF_ERR, {21'h0, ana});
      rd(`ADCSEQ_OFF_STATUS, 33'h7);
      repeat (50) @(posedge pclk);
      cmp({32'h0, done_flag}, 33'h1);
      wr(`ADCSEQ_OFF_STATUS, 32'h7);
      rd(`ADCSEQ_OFF_STATUS, 33'h0);
      // Repeat mode keeps go set, then a go clear stops it
      wr(`ADCSEQ_OFF_CTRL, 32'h1B);
      wait_done(n);
      rd(`ADCSEQ_OFF_CTRL, 33'h1B);
      wr(`ADCSEQ_OFF_CTRL, 32'h09);
      wr(`ADCSEQ_OFF_THRESH, 32'h0FFF);
      repeat (4) @(posedge pclk);
      wr(`ADCSEQ_OFF_STATUS, 32'h7);
      codes = '{1, 27, 30, 2 + ($urandom % 25), 29, 28, 31};
      for (int i = 0; i < 7; i++) begin
         wr(`ADCSEQ_OFF_TRIG, codes[i]);
         if (codes[i] == 29) apb(1'b0, `ADCSEQ_OFF_RESULT, 32'h0, 33'h0, 1'b0);
         else if (codes[i] == 28) apb(1'b0, `ADCSEQ_OFF_ERR, 32'h0, 33'h0, 1'b0);
         else if (codes[i] == 31) wr(`ADCSEQ_OFF_CHAN, $urandom % 64);
         else pulse(codes[i]);
         wait_done(n);
         repeat (4) @(posedge pclk);
         wr(`ADCSEQ_OFF_STATUS, 32'h7);
      end
      wr(`ADCSEQ_OFF_TRIG, 32'h0);
      pulse(0);
      repeat (150) @(posedge pclk);
      cmp({32'h0, done_flag}, 33'h0);
      // Trigger in sleep on the system clock waits for wake
      wr(`ADCSEQ_OFF_TRIG, 32'h5);
      sleep_mode <= 1'b1;
      @(posedge pclk);
      pulse(5);
      repeat (150) @(posedge pclk);
      cmp({32'h0, done_flag}, 33'h0);
      sleep_mode <= 1'b0;
      wait_done(n);
      repeat (4) @(posedge pclk);
      wr(`ADCSEQ_OFF_STATUS, 32'h7);
      // Double sampling: error after every second conversion, result minus previous
      wr(`ADCSEQ_OFF_CTRL, 32'h69);
      wr(`ADCSEQ_OFF_CTRL, 32'h6B);
      wait_done(n);
      repeat (4) @(posedge pclk);
      rd(`ADCSEQ_OFF_ERR, {21'h0, ana});
      wr(`ADCSEQ_OFF_STATUS, 32'h7);
      wr(`ADCSEQ_OFF_CTRL, 32'h6B);
      wait_done(n);
      repeat (4) @(posedge pclk);
      rd(`ADCSEQ_OFF_ERR, 33'h0);
      wr(`ADCSEQ_OFF_STATUS, 32'h7);
      // RC clock in sleep with interrupt enabled
      wr(`ADCSEQ_OFF_CTRL, 32'h8D);
      sleep_mode <= 1'b1;
      @(posedge pclk);
      pulse(5);
      wait_done(n);
      repeat (2) @(posedge pclk);
      cmp({32'h0, wake_req}, 33'h1);
      sleep_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      cmp({32'h0, wake_req}, 33'h0);
      wr(`ADCSEQ_OFF_STATUS, 32'h7);
      // RC clock in sleep with interrupt disabled
      wr(`ADCSEQ_OFF_CTRL, 32'h0D);
      sleep_mode <= 1'b1;
      @(posedge pclk);
      pulse(5);
      wait_done(n);
      repeat (4) @(posedge pclk);
      sleep_mode <= 1'b0;
      @(posedge pclk);
      rd(`ADCSEQ_OFF_STATUS, 33'h0B);
      rd(`ADCSEQ_OFF_CTRL, 33'h0D);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`ADCSEQ_OFF_CTRL, 33'h0);
      rd(`ADCSEQ_OFF_STATUS, 33'h0);
      cmp({1'b0, 32'(exp_q.size())}, 33'h0);
      end_of_test();
   end
endmodule : adc_conversion_sequencer_tb
